// >>> rtl/mtcs_defs.vh
// constants of the transmit configuration and status block
`ifndef MTCS_DEFS_VH
`define MTCS_DEFS_VH

// ****************************************************************
// register indexes (byte address is four times the index)
// ****************************************************************
`define MTCS_IDX_COMMAND 8'h00
`define MTCS_IDX_STATUS 8'h04
`define MTCS_IDX_RETRY 8'h05
`define MTCS_IDX_CONFIG 8'h0D

// ****************************************************************
// configuration fields and reset value
// ****************************************************************
`define MTCS_CFG_CRC_INHIBIT 0
`define MTCS_CFG_LOOP_LOW 1
`define MTCS_CFG_LOOP_HIGH 2
`define MTCS_CFG_REMOTE_DIS 3
`define MTCS_CFG_PRIORITY 4
`define MTCS_CFG_RESET 8'h00

// command field
`define MTCS_CMD_START 0

// ****************************************************************
// status fields and reset value
// ****************************************************************
`define MTCS_ST_DONE_OK 0
`define MTCS_ST_COLLIDED 2
`define MTCS_ST_GAVE_UP 3
`define MTCS_ST_CARRIER_LOST 4
`define MTCS_ST_UNDERRUN 5
`define MTCS_ST_HEARTBEAT 6
`define MTCS_ST_LATE_COL 7
`define MTCS_ST_RESET 8'h00

// ****************************************************************
// loopback modes and remote disable hash bits
// ****************************************************************
`define MTCS_LOOP_NORMAL 2'h0
`define MTCS_LOOP_MAC 2'h1
`define MTCS_LOOP_CODEC 2'h2
`define MTCS_LOOP_EXTERNAL 2'h3
`define MTCS_HASH_DISABLE 6'h3E
`define MTCS_HASH_ENABLE 6'h3F

// ****************************************************************
// backoff and timing
// ****************************************************************
`define MTCS_MAX_ATTEMPTS 5'h10
`define MTCS_BACKOFF_CAP 4'hA
`define MTCS_PRIORITY_COLS 5'h03
`define MTCS_PRIORITY_BASE 4'h3
`define MTCS_CLK_PERIOD_NS 5
`define MTCS_SLOT_NS 51200
`define MTCS_HEARTBEAT_NS 6400
`define MTCS_SYNC_SETTLE 16'h0002
`define MTCS_LFSR_SEED 16'hACE1
`define MTCS_SLOT_CYC (`MTCS_SLOT_NS / `MTCS_CLK_PERIOD_NS)
`define MTCS_HEARTBEAT_CYC (`MTCS_HEARTBEAT_NS / `MTCS_CLK_PERIOD_NS)

`endif

// >>> rtl/mtcs_tx_ctrl.v
// transmit configuration, status and retry sequencing behind an apb slave
//
// What this block does
// - write-only config register at index 0Dh, loopback bits reset to zero
// - frame check sequence appended when inhibit bit is 0, omitted when 1
// - crc inhibit setting applies in every loopback mode as well
// - loopback bits: 00 normal, 01 mac, 10 line codec, 11 external
// - loop pin high only in line codec loopback mode
// - remote disable enabled: hash bit 62 disables, bit 63 re-enables transmitter
// - clearing remote disable enable also re-enables the transmitter
// - priority bit: first three backoffs span 2^min(3+n,10) slots
// - priority bit clear: normal truncated binary exponential backoff
// - read-only status at index 04h, cleared when next transmission starts
// - each status bit stays low unless its event occurs
// - done ok set only without give-up and without underrun
// - collided bit on any collision, count kept in retry count register
// - abort and set gave-up bit after 16 collided attempts
// - carrier loss sets its bit but transmission goes on
// - fifo underrun sets its bit and aborts the frame
// - heartbeat bit set if no collision in first 6.4 us after frame
// - collision after 51.2 us slot sets late bit, retried normally
// - status reads zero from reset until the first transmission
//
// Implementation choice: the APB register port.
`timescale 1ns/10ps
`default_nettype none
`include "mtcs_defs.vh"

module mtcs_tx_ctrl #(
   parameter SLOT_CYC = `MTCS_SLOT_CYC,
   parameter HB_CYC = `MTCS_HEARTBEAT_CYC
) (
   input wire pclk,
   input wire presetn,
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [11:0] paddr,
   input wire [31:0] pwdata,
   output reg [31:0] prdata,
   output reg pready,
   output reg pslverr,
   input wire carrier_in,
   input wire collision_in,
   input wire frame_done,
   input wire fifo_underrun,
   input wire hash_hit,
   input wire [5:0] hash_index,
   output reg tx_en,
   output reg tx_crc_inhibit,
   output reg [1:0] loop_mode,
   output reg loop_pin,
   output reg tx_busy,
   output reg tx_disabled
);

   // ****************************************************************
   // local declarations
   // ****************************************************************
   localparam ST_IDLE = 2'h0;
   localparam ST_SEND = 2'h1;
   localparam ST_BACKOFF = 2'h2;
   localparam ST_HBEAT = 2'h3;
   // reset value kept whole so each config flop takes its own bit
   localparam [7:0] CFG_RST = `MTCS_CFG_RESET;
   // samples the synchroniser may still carry from the last attempt
   localparam [15:0] SETTLE_CYC = `MTCS_SYNC_SETTLE;

   reg [1:0] state;
   reg remote_tx_disable_enable;
   reg backoff_priority_enable;
   reg [7:0] tx_status_register;
   reg [4:0] retry_count_register;
   reg start_pend;
   reg carrier_meta, carrier_s, collision_meta, collision_s;
   reg carrier_seen, hb_seen;
   reg [15:0] lfsr;
   reg [15:0] elapsed;
   reg [15:0] slot_cnt;
   reg [9:0] slots_left;
   reg [15:0] hb_cnt;
   reg [3:0] next_exp;
   reg [9:0] next_mask;
   reg [4:0] next_count;
   reg [31:0] next_rdata;
   reg next_hit;
   wire [7:0] idx;
   wire setup;
   wire wr_access;
   wire cfg_write;
   wire cmd_write;
   wire [1:0] cfg_loop;
   wire carrier_check;
   wire late_hit;
   wire give_up;
   wire slot_end;
   wire hb_end;
   wire [9:0] pick_slots;

   assign idx = paddr[9:2];
   assign setup = psel & ~penable;
   assign wr_access = psel & penable & pwrite & pready;

   // ****************************************************************
   // write decode
   // ****************************************************************
   // writes land only at the edge that closes the access cycle
   assign cfg_write = wr_access & (idx == `MTCS_IDX_CONFIG);
   assign cmd_write = wr_access & (idx == `MTCS_IDX_COMMAND) & pwdata[`MTCS_CMD_START];
   // bits 7:5 of the config word are reserved and dropped
   assign cfg_loop = {pwdata[`MTCS_CFG_LOOP_HIGH], pwdata[`MTCS_CFG_LOOP_LOW]};

   // ****************************************************************
   // pin synchronisers
   // ****************************************************************
   // carrier and collision come from the transceiver, another domain
   // only the second stage is read by logic; the first may be metastable
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         carrier_meta <= 1'b0;
         carrier_s <= 1'b0;
         collision_meta <= 1'b0;
         collision_s <= 1'b0;
      end else begin
         carrier_meta <= carrier_in;
         carrier_s <= carrier_meta;
         collision_meta <= collision_in;
         collision_s <= collision_meta;
      end
   end

   // ****************************************************************
   // apb read mux and decode
   // ****************************************************************
   // config reads as zero: the register is write-only
   // status read mid-frame shows the events gathered so far
   always @* begin
      next_rdata = 32'h00000000;
      next_hit = 1'b1;
      case (idx)
         `MTCS_IDX_COMMAND: next_rdata = {31'h00000000, start_pend | tx_busy};
         `MTCS_IDX_STATUS: next_rdata = {24'h000000, tx_status_register};
         `MTCS_IDX_RETRY: next_rdata = {27'h0000000, retry_count_register};
         `MTCS_IDX_CONFIG: next_rdata = 32'h00000000;
         default: next_hit = 1'b0;
      endcase
   end

   // answer in the first access cycle, no wait states
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready <= 1'b0;
         prdata <= 32'h00000000;
         pslverr <= 1'b0;
      end else begin
         pready <= setup;
         pslverr <= setup & ~next_hit;
         if (setup && !pwrite) begin
            prdata <= next_rdata;
         end
      end
   end

   // ****************************************************************
   // configuration register
   // ****************************************************************
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         tx_crc_inhibit <= CFG_RST[`MTCS_CFG_CRC_INHIBIT];
         loop_mode <= {CFG_RST[`MTCS_CFG_LOOP_HIGH], CFG_RST[`MTCS_CFG_LOOP_LOW]};
         remote_tx_disable_enable <= CFG_RST[`MTCS_CFG_REMOTE_DIS];
         backoff_priority_enable <= CFG_RST[`MTCS_CFG_PRIORITY];
         loop_pin <= 1'b0;
      end else if (cfg_write) begin
         // inhibit drives the crc generator in every mode
         tx_crc_inhibit <= pwdata[`MTCS_CFG_CRC_INHIBIT];
         loop_mode <= cfg_loop;
         loop_pin <= (cfg_loop == `MTCS_LOOP_CODEC);
         remote_tx_disable_enable <= pwdata[`MTCS_CFG_REMOTE_DIS];
         backoff_priority_enable <= pwdata[`MTCS_CFG_PRIORITY];
      end
   end

   // ****************************************************************
   // remote transmitter disable
   // ****************************************************************
   // a frame already on the wire finishes; only new starts are held
   // clearing the enable wins over a disable hash in the same cycle
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         tx_disabled <= 1'b0;
      end else if (!remote_tx_disable_enable) begin
         tx_disabled <= 1'b0;
      end else if (hash_hit && hash_index == `MTCS_HASH_DISABLE) begin
         tx_disabled <= 1'b1;
      end else if (hash_hit && hash_index == `MTCS_HASH_ENABLE) begin
         tx_disabled <= 1'b0;
      end
   end

   // ****************************************************************
   // backoff range
   // ****************************************************************
   // exponent from the collision count after this collision
   always @* begin
      next_count = retry_count_register + 5'h01;
      if (backoff_priority_enable && next_count <= `MTCS_PRIORITY_COLS) begin
         next_exp = `MTCS_PRIORITY_BASE + next_count[3:0];
      end else if (next_count > {1'b0, `MTCS_BACKOFF_CAP}) begin
         next_exp = `MTCS_BACKOFF_CAP;
      end else begin
         next_exp = next_count[3:0];
      end
      next_mask = ~(10'h3FF << next_exp);
   end

   // free-running lfsr feeds the random slot pick
   // any non-zero seed will do; zero would lock the register up
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         lfsr <= `MTCS_LFSR_SEED;
      end else begin
         lfsr <= {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};
      end
   end

   // ****************************************************************
   // start request
   // ****************************************************************
   // a start written while busy waits here until the sequencer is idle
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         start_pend <= 1'b0;
      end else if (cmd_write) begin
         start_pend <= 1'b1;
      end else if (state == ST_IDLE && !tx_disabled) begin
         start_pend <= 1'b0;
      end
   end

   // ****************************************************************
   // attempt timing
   // ****************************************************************
   // the synchroniser still shows the last attempt's carrier for two
   // cycles after a zero-slot retry; judging carrier then would flag
   // a loss that never happened, so those samples are skipped
   assign carrier_check = (elapsed >= SETTLE_CYC);
   // late only past one full slot; such collisions still retry
   assign late_hit = (elapsed >= SLOT_CYC[15:0]);
   // the sixteenth collided attempt is the last one
   assign give_up = (next_count == `MTCS_MAX_ATTEMPTS);
   // random pick bounded by the backoff range of this collision
   assign pick_slots = lfsr[9:0] & next_mask;
   assign slot_end = (slot_cnt == SLOT_CYC[15:0] - 16'h0001);
   // heartbeat window is fixed; a heartbeat after it counts as missing
   assign hb_end = (hb_cnt == HB_CYC[15:0] - 16'h0001);

   // ****************************************************************
   // transmit sequencer
   // ****************************************************************
   // status flags only ever set here; the clear happens at start,
   // when no event can arrive, so no set is lost
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state <= ST_IDLE;
         tx_en <= 1'b0;
         tx_busy <= 1'b0;
         tx_status_register <= `MTCS_ST_RESET;
         retry_count_register <= 5'h00;
         carrier_seen <= 1'b0;
         hb_seen <= 1'b0;
         elapsed <= 16'h0000;
         slot_cnt <= 16'h0000;
         slots_left <= 10'h000;
         hb_cnt <= 16'h0000;
      end else begin
         case (state)
            ST_IDLE: begin
               if (start_pend && !tx_disabled) begin
                  // the only clear the status bits see outside reset
                  tx_status_register <= 8'h00;
                  retry_count_register <= 5'h00;
                  carrier_seen <= 1'b0;
                  elapsed <= 16'h0000;
                  tx_en <= 1'b1;
                  tx_busy <= 1'b1;
                  state <= ST_SEND;
               end
            end
            ST_SEND: begin
               if (elapsed != 16'hFFFF) begin
                  elapsed <= elapsed + 16'h0001;
               end
               if (carrier_check && carrier_s) begin
                  carrier_seen <= 1'b1;
               end else if (carrier_check && carrier_seen) begin
                  // keep sending on loss of carrier
                  tx_status_register[`MTCS_ST_CARRIER_LOST] <= 1'b1;
               end
               // underrun beats collision and frame end in the same cycle
               if (fifo_underrun) begin
                  tx_status_register[`MTCS_ST_UNDERRUN] <= 1'b1;
                  tx_en <= 1'b0;
                  tx_busy <= 1'b0;
                  state <= ST_IDLE;
               end else if (collision_s) begin
                  tx_en <= 1'b0;
                  tx_status_register[`MTCS_ST_COLLIDED] <= 1'b1;
                  retry_count_register <= next_count;
                  if (late_hit) begin
                     tx_status_register[`MTCS_ST_LATE_COL] <= 1'b1;
                  end
                  if (give_up) begin
                     tx_status_register[`MTCS_ST_GAVE_UP] <= 1'b1;
                     tx_busy <= 1'b0;
                     state <= ST_IDLE;
                  end else begin
                     // late collisions retry like any other
                     slots_left <= pick_slots;
                     slot_cnt <= 16'h0000;
                     state <= ST_BACKOFF;
                  end
               end else if (frame_done) begin
                  tx_status_register[`MTCS_ST_DONE_OK] <= 1'b1;
                  tx_en <= 1'b0;
                  hb_seen <= 1'b0;
                  hb_cnt <= 16'h0000;
                  state <= ST_HBEAT;
               end
            end
            ST_BACKOFF: begin
               // the retry goes out without deferring to carrier
               if (slots_left == 10'h000) begin
                  elapsed <= 16'h0000;
                  carrier_seen <= 1'b0;
                  tx_en <= 1'b1;
                  state <= ST_SEND;
               end else if (slot_end) begin
                  slot_cnt <= 16'h0000;
                  slots_left <= slots_left - 10'h001;
               end else begin
                  slot_cnt <= slot_cnt + 16'h0001;
               end
            end
            ST_HBEAT: begin
               // heartbeat must begin inside the early gap window
               // busy spans the window so status is final once it falls
               if (collision_s) begin
                  hb_seen <= 1'b1;
               end
               if (hb_end) begin
                  if (!hb_seen && !collision_s) begin
                     tx_status_register[`MTCS_ST_HEARTBEAT] <= 1'b1;
                  end
                  tx_busy <= 1'b0;
                  state <= ST_IDLE;
               end else begin
                  hb_cnt <= hb_cnt + 16'h0001;
               end
            end
            default: begin
               // unused state code: back to idle with the line quiet
               tx_en <= 1'b0;
               tx_busy <= 1'b0;
               state <= ST_IDLE;
            end
         endcase
      end
   end

endmodule // mtcs_tx_ctrl

`default_nettype wire

// >>> testbench/mtcs_tx_ctrl_props.sv
// concurrent checks on the transmit config and status block ports
`timescale 1ns/10ps
`default_nettype none
module mtcs_tx_ctrl_props #(
   parameter SLOT_CYC = 10240,
   parameter HB_CYC = 1280
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic frame_done,
   input wire logic fifo_underrun,
   input wire logic tx_en,
   input wire logic tx_crc_inhibit,
   input wire logic [1:0] loop_mode,
   input wire logic loop_pin,
   input wire logic tx_busy,
   input wire logic tx_disabled
);
   // ********
   // access decode
   // ********
   wire logic acc = psel && penable && pready;
   wire logic cfg = paddr[9:2] == 8'h0D;
   wire logic mapped = paddr[9:2] inside {8'h00, 8'h04, 8'h05, 8'h0D};
   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);
   // register side
   AST_SETUP_ANSWER: assert property (psel && !penable |=> pready)
      else $error("no answer in first access cycle");
   AST_CFG_WRITE: assert property (acc && pwrite && cfg |=> {loop_mode, tx_crc_inhibit} == $past(pwdata[2:0]))
      else $error("config write not applied");
   AST_CFG_WRITE_ONLY: assert property (acc && !pwrite && cfg |-> prdata == 32'h0 && !pslverr)
      else $error("config register readable");
   AST_UNMAPPED: assert property (acc && !mapped |-> pslverr)
      else $error("unmapped access without error");
   AST_LOOP_PIN_ON: assert property ((loop_mode == 2'h2) [*2] |-> loop_pin)
      else $error("loop pin low in codec loopback");
   AST_LOOP_PIN_OFF: assert property (loop_mode != 2'h2 ##1 loop_mode != 2'h2 |-> !loop_pin)
      else $error("loop pin high outside codec loopback");
   // transmit side
   AST_CLEAR_REENABLES: assert property (acc && pwrite && cfg && !pwdata[3] |-> ##[1:2] !tx_disabled)
      else $error("clearing remote disable did not re-enable");
   AST_HELD_WHILE_DISABLED: assert property (tx_disabled && !tx_busy |=> !tx_en)
      else $error("transmit started while remotely disabled");
   AST_UNDERRUN_ABORTS: assert property (tx_en && fifo_underrun |-> ##[1:3] !tx_en && !tx_busy)
      else $error("underrun did not abort the frame");
   AST_DONE_ENDS_TRY: assert property (tx_en && frame_done && !fifo_underrun |=> !tx_en ##1 tx_busy [*2])
      else $error("frame end did not open the heartbeat window");
   cover property (tx_disabled && !tx_busy);
   cover property (acc && pslverr);
   cover property (tx_en && fifo_underrun);
endmodule // mtcs_tx_ctrl_props
bind mtcs_tx_ctrl mtcs_tx_ctrl_props #(.SLOT_CYC(SLOT_CYC), .HB_CYC(HB_CYC)) u_props (.pclk, .presetn, .psel,
   .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .frame_done, .fifo_underrun, .tx_en,
   .tx_crc_inhibit, .loop_mode, .loop_pin, .tx_busy, .tx_disabled);
`default_nettype wire

// >>> testbench/mtcs_medium_model.sv
// behavioural model of the medium and transmit fifo beside the block
`timescale 1ns/10ps
`default_nettype none
module mtcs_medium_model #(
   parameter int SLOT_CYC = 16
) (
   input wire logic pclk,
   input wire logic tx_en,
   input wire logic tx_busy,
   input wire logic [1:0] mode,
   input wire logic [4:0] ncol,
   input wire logic late,
   input wire logic hb_on,
   output logic carrier_in,
   output logic collision_in = 1'b0,
   output logic frame_done = 1'b0,
   output logic fifo_underrun = 1'b0
);
   // ********
   // attempt sequencing
   // ********
   int cnt = 0;
   int att = 0;
   int hb_wait = 0;
   logic tx_q = 1'b0;
   // mode 0 clean frame, 1 fifo runs dry, 2 carrier drops mid-frame
   always @(posedge pclk) begin
      frame_done <= 1'b0;
      fifo_underrun <= 1'b0;
      tx_q <= tx_en;
      cnt <= tx_en ? cnt + 1 : 0;
      hb_wait <= (hb_wait > 0) ? hb_wait - 1 : 0;
      // one-cycle jam: a longer one could hit a zero-slot retry twice
      collision_in <= (tx_en && att < ncol && cnt == (late ? SLOT_CYC + 3 : 2)) || (hb_on && hb_wait == 1);
      if (!tx_busy)
         att <= 0;
      else if (tx_q && !tx_en)
         att <= att + 1;
      if (tx_en && att >= ncol && cnt == 20) begin
         fifo_underrun <= (mode == 2'h1);
         frame_done <= (mode != 2'h1);
         hb_wait <= 3;
      end
   end
   // carrier follows own transmission unless the scenario drops it
   assign carrier_in = tx_en && !(mode == 2'h2 && cnt > 6);
endmodule // mtcs_medium_model
`default_nettype wire

// >>> testbench/tb_top.sv
// self-checking bench for the transmit config and status block
`timescale 1ns/10ps
`default_nettype none
module tb_top;
   localparam int SLOT = 8;
   localparam int HB = 12;
   logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0, rd, w, exp_cfg;
   logic hash_hit = 1'b0, late = 1'b0, hb_on = 1'b1, er;
   logic [5:0] hash_index = 6'h00;
   logic [1:0] mode = 2'h0;
   logic [4:0] ncol = 5'h00;
   int err_total = 0, samples_checked = 0, cyc = 0;
   wire logic [31:0] prdata;
   wire logic [1:0] loop_mode;
   wire logic pready, pslverr, carrier_in, collision_in, frame_done, fifo_underrun;
   wire logic tx_en, tx_crc_inhibit, loop_pin, tx_busy, tx_disabled;

   mtcs_tx_ctrl #(.SLOT_CYC(SLOT), .HB_CYC(HB)) u_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
      .pwdata, .prdata, .pready, .pslverr, .carrier_in, .collision_in, .frame_done, .fifo_underrun, .hash_hit,
      .hash_index, .tx_en, .tx_crc_inhibit, .loop_mode, .loop_pin, .tx_busy, .tx_disabled);
   mtcs_medium_model #(.SLOT_CYC(SLOT)) u_medium (.pclk, .tx_en, .tx_busy, .mode, .ncol, .late, .hb_on,
      .carrier_in, .collision_in, .frame_done, .fifo_underrun);

   // ********
   // clock and hang guard
   // ********
   initial begin
      forever #2.5 pclk = ~pclk;
   end
   // ceiling well above the worst give-up backoff
   always @(posedge pclk) begin
      cyc++;
      if (cyc == 100000) begin
         err_total++;
         tally_and_finish();
      end
   end

   // ********
   // helpers
   // ********
   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      samples_checked++;
      if (got !== exp) begin
         err_total++;
         $display("unexpected %s: expected %h seen %h", what, exp, got);
      end
   endtask
   // one apb transfer, held until pready is sampled high
   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask
   task automatic hash(input logic [5:0] h);
      hash_hit <= 1'b1;
      hash_index <= h;
      @(posedge pclk);
      hash_hit <= 1'b0;
      repeat (3) @(posedge pclk);
   endtask
   task automatic wait_idle();
      int n;
      n = 0;
      while (tx_busy !== 1'b1 && n < 20) begin
         @(posedge pclk);
         n++;
      end
      while (tx_busy !== 1'b0 && n < 80000) begin
         @(posedge pclk);
         n++;
      end
   endtask
   // status expected from the collision count, late flag, mode and heartbeat
   function automatic logic [7:0] exp_status(input logic [4:0] nc, input logic lt, input logic [1:0] md, input logic hb);
      logic [7:0] s;
      s = (nc != 5'h00) ? 8'h04 : 8'h00;
      if (lt && nc != 5'h00) s = s | 8'h80;
      if (nc >= 5'h10) return s | 8'h08;
      if (md == 2'h1) return s | 8'h20;
      s = s | 8'h01 | ((md == 2'h2) ? 8'h10 : 8'h00);
      return hb ? s : (s | 8'h40);
   endfunction
   task automatic send(input logic [1:0] md, input logic [4:0] nc, input logic lt, input logic hb);
      mode <= md;
      ncol <= nc;
      late <= lt;
      hb_on <= hb;
      apb(1'b1, 12'h000, 32'h1);
      wait_idle();
      apb(1'b0, 12'h010, 32'h0);
      chk("tx status", {24'h0, exp_status(nc, lt, md, hb)}, rd);
      apb(1'b0, 12'h014, 32'h0);
      chk("retry count", {27'h0, nc}, rd);
   endtask
   task automatic tally_and_finish();
      if (err_total == 0 && samples_checked > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask

   // ********
   // main sequence
   // ********
   initial begin
      void'($urandom(75822));
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      chk("loop mode at reset", 32'h0, {30'h0, loop_mode});
      // every crc and loopback setting, reserved bits random
      // host side: data config loopback bit taken as cleared here
      for (int i = 0; i < 32; i++) begin
         w = ($urandom() & 32'hFFFFFFE0) | i;
         apb(1'b1, 12'h034, w);
         exp_cfg = {28'h0, w[2:1] == 2'h2, w[2:1], w[0]};
         chk("config outputs", exp_cfg, {28'h0, loop_pin, loop_mode, tx_crc_inhibit});
      end
      apb(1'b0, 12'h034, 32'h0);
      chk("config read", 32'h0, rd);
      apb(1'b0, 12'h080, 32'h0);
      chk("unmapped error", 32'h1, {31'h0, er});
      apb(1'b1, 12'h034, 32'h0);
      send(2'h0, 5'h00, 1'b0, 1'b1);
      send(2'h0, 5'h00, 1'b0, 1'b0);
      send(2'h1, 5'h00, 1'b0, 1'b1);
      send(2'h2, 5'h00, 1'b0, 1'b1);
      send(2'h0, 5'h10, 1'b0, 1'b1);
      send(2'h0, 5'h03, 1'b1, 1'b1);
      // random retry counts under either backoff flavour
      repeat (4) begin
         apb(1'b1, 12'h034, {27'h0, 1'($urandom()), 4'h0});
         send(2'h0, 5'($urandom_range(6, 1)), 1'b0, 1'($urandom()));
      end
      ncol <= 5'h00;
      hb_on <= 1'b1;
      apb(1'b1, 12'h034, 32'h8);
      hash(6'h3E);
      chk("disabled by hash", 32'h1, {31'h0, tx_disabled});
      apb(1'b1, 12'h000, 32'h1);
      repeat (30) @(posedge pclk);
      chk("start held", 32'h0, {31'h0, tx_busy});
      apb(1'b0, 12'h000, 32'h0);
      chk("start pending", 32'h1, rd);
      hash(6'h3F);
      chk("enabled by hash", 32'h0, {31'h0, tx_disabled});
      wait_idle();
      apb(1'b0, 12'h010, 32'h0);
      chk("held frame status", 32'h1, rd);
      hash(6'h3E);
      apb(1'b1, 12'h034, 32'h0);
      @(posedge pclk);
      chk("enabled by clearing", 32'h0, {31'h0, tx_disabled});
      hash(6'h3E);
      chk("hash ignored when off", 32'h0, {31'h0, tx_disabled});
      tally_and_finish();
   end
endmodule // tb_top
`default_nettype wire
